// ===== fsps_cpu_model.sv
`timescale 1ns/1ns
`default_nettype none
module fsps_cpu_model (
  // Clock and halt
  input wire logic i_clk,
  input wire logic i_halt,
  // Instruction side
  output logic o_instr,
  output logic [12:0] o_pointer,
  output logic [15:0] o_data
);
  initial begin
    o_instr = 1'b0;
    o_pointer = 13'h0000;
    o_data = 16'h0000;
  end
  task automatic store_program_instr(input logic [12:0] ptr, input logic [15:0] dat);
    while (i_halt === 1'b1) @(posedge i_clk);
    @(posedge i_clk);
    o_instr <= 1'b1;
    o_pointer <= ptr;
    o_data <= dat;
    @(posedge i_clk);
    o_instr <= 1'b0;
    // Operands are not held afterwards, so show their inverse
    o_pointer <= ~ptr;
    o_data <= ~dat;
  endtask : store_program_instr
endmodule : fsps_cpu_model
`default_nettype wire

// ===== fsps_op_timer.sv
`timescale 1ns/1ns
`default_nettype none
module fsps_op_timer #(
  parameter int CYCLES = 82000
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Control
  input wire logic i_start,
  // Status
  output logic o_busy,
  output logic o_done
);
  initial begin
    if (CYCLES < 2) $error("fsps_op_timer: CYCLES too small");
  end
  localparam int CW = $clog2(CYCLES + 1);
  logic [CW-1:0] cnt_reg;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg <= '0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_start && !o_busy) begin
        cnt_reg <= CW'(CYCLES - 1);
        o_busy <= 1'b1;
      end else if (o_busy) begin
        if (cnt_reg == '0) begin
          o_busy <= 1'b0;
          o_done <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg - 1'b1;
        end
      end
    end
  end
endmodule : fsps_op_timer
`default_nettype wire

// ===== fsps_page_buf.sv
`timescale 1ns/1ns
`default_nettype none
module fsps_page_buf #(
  parameter int WORDS = 32,
  parameter int AW = 5
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Control
  input wire logic i_clear,
  input wire logic i_load,
  input wire logic [AW-1:0] i_word_addr,
  input wire logic [15:0] i_data,
  input wire logic [AW-1:0] i_rd_addr,
  // Readout
  output logic [15:0] o_rd_data,
  output logic o_any_loaded
);
  initial begin
    if (WORDS != (1 << AW)) $error("fsps_page_buf: WORDS must be 2**AW");
  end
  // Erased flash words read all ones, so the cleared buffer holds ones
  logic [15:0] mem_reg [WORDS];
  logic [WORDS-1:0] valid_reg;
  genvar g;
  generate
    for (g = 0; g < WORDS; g++) begin : g_word
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          mem_reg[g] <= 16'hFFFF;
          valid_reg[g] <= 1'b0;
        end else if (i_clear) begin
          mem_reg[g] <= 16'hFFFF;
          valid_reg[g] <= 1'b0;
        end else if (i_load && (i_word_addr == AW'(g))) begin
          // Random order loading is fine; a repeat load merges by AND
          mem_reg[g] <= mem_reg[g] & i_data;
          valid_reg[g] <= 1'b1;
        end
      end
    end
  endgenerate
  assign o_rd_data = mem_reg[i_rd_addr];
  assign o_any_loaded = |valid_reg;
endmodule : fsps_page_buf
`default_nettype wire

// ===== fsps_pkg.sv
package fsps_pkg;
  // Control register layout (low byte of the program store control register)
  localparam int CTRL_W = 8;
  localparam int BIT_ENABLE = 0;
  localparam int BIT_ERASE = 1;
  localparam int BIT_WRITE = 2;
  localparam int BIT_CLEAR = 4;
  localparam logic [7:0] CMD_LOAD = 8'h01;
  localparam logic [7:0] CMD_ERASE = 8'h03;
  localparam logic [7:0] CMD_WRITE = 8'h05;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_RD_MASK = 8'h17;
  // Register index on the plain port
  localparam logic [1:0] ADDR_CTRL = 2'h0;
  localparam logic [1:0] ADDR_STATUS = 2'h1;
  // Arming window in clock cycles
  localparam int ARM_CYCLES = 4;
  // Flash operation timing
  localparam int CLK_HZ = 20000000;
  localparam int OP_MIN_US = 3700;
  localparam int OP_MAX_US = 4500;
  localparam int OP_MIN_CYC = (OP_MIN_US * (CLK_HZ / 1000000));
  localparam int OP_MAX_CYC = (OP_MAX_US * (CLK_HZ / 1000000));
  // Chosen programming time lies between the two bounds
  localparam int OP_CYC = (OP_MIN_CYC + OP_MAX_CYC) / 2;
  typedef enum logic [2:0] {
    FSPS_IDLE = 3'b001,
    FSPS_ERASE = 3'b010,
    FSPS_WRITE = 3'b100
  } fsps_state_e;
endpackage : fsps_pkg

// ===== fsps_sequencer.sv
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Store-program instruction ignored unless enable fuse reads zero.
// - Program memory is written one whole page from the buffer.
// - One word loads per instruction, before erase or between erase and write.
// - Buffer words may be loaded in any order.
// - Control value 03 plus instruction within four cycles starts page erase.
// - Erase uses only the page field of the pointer.
// - CPU halted for the whole erase.
// - Control value 01 plus instruction within four cycles loads one word.
// - Word-in-page field selects the buffer word loaded.
// - Buffer clears after page write, on clear bit, and on reset.
// - Data EEPROM write during page loading discards loaded words.
// - Control value 05 plus instruction within four cycles starts page write.
// - CPU halted for the whole page write.
// - Armed command clears on completion or after four idle cycles.
// - Programming requests blocked while data EEPROM write runs.
// - Erase and write each last between 3.7 ms and 4.5 ms.
module fsps_sequencer
  import fsps_pkg::*;
#(
  parameter int WORD_BITS = 5,
  parameter int PAGE_BITS = 7,
  parameter int OP_CYCLES = fsps_pkg::OP_CYC
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Fuse and system status
  input wire logic i_self_program_enable,
  input wire logic i_eeprom_busy,
  // Register port
  input wire logic [1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // CPU instruction side
  input wire logic i_store_program_instr,
  input wire logic [PAGE_BITS+WORD_BITS:0] i_pointer,
  input wire logic [15:0] i_load_data_pair,
  output logic o_cpu_halt,
  // Flash array side
  output logic o_flash_erase,
  output logic o_flash_write,
  output logic [PAGE_BITS-1:0] o_flash_page,
  output logic [WORD_BITS-1:0] o_flash_word,
  output logic [15:0] o_flash_data,
  output logic o_flash_we
);
  import fsps_pkg::*;
  localparam int WORDS = 1 << WORD_BITS;
  initial begin
    if (WORD_BITS < 1 || PAGE_BITS < 1) $error("fsps_sequencer: bad field widths");
    // Halt stands one cycle past the timer, so that cycle counts too
    if (OP_CYCLES < OP_MIN_CYC || OP_CYCLES + 1 > OP_MAX_CYC) begin
      $error("fsps_sequencer: operation time outside 3.7 to 4.5 ms");
    end
  end

  // Pointer fields: bit 0 is the byte select, unused for programming
  logic [WORD_BITS-1:0] ptr_word;
  logic [PAGE_BITS-1:0] ptr_page;
  assign ptr_word = i_pointer[WORD_BITS:1];
  assign ptr_page = i_pointer[PAGE_BITS+WORD_BITS:WORD_BITS+1];

  fsps_state_e state_reg;
  logic [CTRL_W-1:0] program_store_control_reg;
  logic [2:0] arm_cnt_reg;
  logic armed;
  logic ctrl_wr;
  logic instr_ok;
  logic do_load;
  logic do_erase;
  logic do_write;
  logic buf_clear;
  logic timer_busy;
  logic timer_done;
  logic timer_start;
  logic any_loaded;
  logic [15:0] buf_rd_data;
  logic [WORD_BITS-1:0] wr_idx_reg;
  logic wr_run_reg;
  logic eeprom_busy_q_reg;

  // Writes are refused while an EEPROM write or a flash operation runs
  assign ctrl_wr = i_wr && (i_addr == ADDR_CTRL) && !i_eeprom_busy && (state_reg == FSPS_IDLE);
  assign armed = program_store_control_reg[BIT_ENABLE] && (arm_cnt_reg != 3'h0);
  assign instr_ok = i_store_program_instr && armed && !i_self_program_enable && !i_eeprom_busy;
  assign do_load = instr_ok && (program_store_control_reg == CMD_LOAD);
  assign do_erase = instr_ok && (program_store_control_reg == CMD_ERASE);
  assign do_write = instr_ok && (program_store_control_reg == CMD_WRITE);
  assign timer_start = do_erase || do_write;

  // Control register and its arming window
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      program_store_control_reg <= CTRL_RESET;
      arm_cnt_reg <= 3'h0;
    end else if (ctrl_wr) begin
      // Clear bit is a strobe and never stays set
      program_store_control_reg <= i_wdata & ~(8'h01 << BIT_CLEAR);
      arm_cnt_reg <= 3'(ARM_CYCLES);
    end else if (state_reg != FSPS_IDLE) begin
      if (timer_done) begin
        program_store_control_reg <= CTRL_RESET;
      end
    end else if (do_load) begin
      program_store_control_reg <= CTRL_RESET;
      arm_cnt_reg <= 3'h0;
    end else if (timer_start) begin
      arm_cnt_reg <= 3'h0;
    end else if (arm_cnt_reg != 3'h0) begin
      arm_cnt_reg <= arm_cnt_reg - 3'h1;
      if (arm_cnt_reg == 3'h1) begin
        program_store_control_reg <= CTRL_RESET;
      end
    end
  end

  // Sequencer state
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= FSPS_IDLE;
    end else begin
      case (state_reg)
        FSPS_IDLE: begin
          if (do_erase) begin
            state_reg <= FSPS_ERASE;
          end else if (do_write) begin
            state_reg <= FSPS_WRITE;
          end
        end
        FSPS_ERASE: begin
          if (timer_done) begin
            state_reg <= FSPS_IDLE;
          end
        end
        FSPS_WRITE: begin
          if (timer_done) begin
            state_reg <= FSPS_IDLE;
          end
        end
        default: begin
          state_reg <= FSPS_IDLE;
        end
      endcase
    end
  end

  // Whole-page transfer to the array, one word per cycle at write start
  // A run flag ends the burst after the last word, so each word goes out once
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_idx_reg <= '0;
      wr_run_reg <= 1'b0;
      o_flash_we <= 1'b0;
      o_flash_word <= '0;
      o_flash_data <= 16'hFFFF;
    end else begin
      o_flash_we <= 1'b0;
      if (do_write) begin
        wr_idx_reg <= '0;
        wr_run_reg <= 1'b1;
      end else if (wr_run_reg && timer_busy) begin
        o_flash_we <= 1'b1;
        o_flash_word <= wr_idx_reg;
        o_flash_data <= buf_rd_data;
        wr_idx_reg <= wr_idx_reg + 1'b1;
        if (wr_idx_reg == WORD_BITS'(WORDS - 1)) begin
          wr_run_reg <= 1'b0;
        end
      end
    end
  end

  // Flash controls and CPU halt come from flops
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cpu_halt <= 1'b0;
      o_flash_erase <= 1'b0;
      o_flash_write <= 1'b0;
      o_flash_page <= '0;
    end else begin
      if (timer_start) begin
        o_cpu_halt <= 1'b1;
        o_flash_erase <= do_erase;
        o_flash_write <= do_write;
        o_flash_page <= ptr_page;
      end else if (timer_done) begin
        o_cpu_halt <= 1'b0;
        o_flash_erase <= 1'b0;
        o_flash_write <= 1'b0;
      end
    end
  end

  // EEPROM write start while words are loaded drops them
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      eeprom_busy_q_reg <= 1'b0;
    end else begin
      eeprom_busy_q_reg <= i_eeprom_busy;
    end
  end

  assign buf_clear = (state_reg == FSPS_WRITE && timer_done)
    || (ctrl_wr && i_wdata[BIT_CLEAR])
    || (i_eeprom_busy && !eeprom_busy_q_reg && any_loaded);

  fsps_page_buf #(
    .WORDS(WORDS),
    .AW(WORD_BITS)
  ) u_buf (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_clear(buf_clear),
    .i_load(do_load),
    .i_word_addr(ptr_word),
    .i_data(i_load_data_pair),
    .i_rd_addr(wr_idx_reg),
    .o_rd_data(buf_rd_data),
    .o_any_loaded(any_loaded)
  );

  fsps_op_timer #(
    .CYCLES(OP_CYCLES)
  ) u_timer (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_start(timer_start),
    .o_busy(timer_busy),
    .o_done(timer_done)
  );

  // Read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        ADDR_CTRL: o_rdata <= program_store_control_reg & CTRL_RD_MASK;
        ADDR_STATUS: o_rdata <= {5'h00, any_loaded, o_cpu_halt, armed};
        default: o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end
endmodule : fsps_sequencer
`default_nettype wire

// ===== fsps_sequencer_properties.sv
`timescale 1ns/1ns
`default_nettype none
module fsps_sequencer_properties
  import fsps_pkg::*;
#(
  parameter int WORD_BITS = 5,
  parameter int PAGE_BITS = 7
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Watched inputs
  input wire logic i_self_program_enable,
  input wire logic i_eeprom_busy,
  input wire logic [1:0] i_addr,
  input wire logic i_wr,
  input wire logic i_store_program_instr,
  input wire logic [PAGE_BITS+WORD_BITS:0] i_pointer,
  // Watched outputs
  input wire logic o_cpu_halt,
  input wire logic o_flash_erase,
  input wire logic o_flash_write,
  input wire logic [PAGE_BITS-1:0] o_flash_page,
  input wire logic [WORD_BITS-1:0] o_flash_word,
  input wire logic o_flash_we
);
  int halt_cnt_reg;
  int since_wr_reg;
  logic [PAGE_BITS-1:0] ptr_page;
  assign ptr_page = i_pointer[PAGE_BITS+WORD_BITS:WORD_BITS+1];
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) halt_cnt_reg <= 0;
    else halt_cnt_reg <= o_cpu_halt ? halt_cnt_reg + 1 : 0;
  end
  // Saturates so a stale arming can never look fresh
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) since_wr_reg <= 9;
    else if (i_wr && i_addr == ADDR_CTRL) since_wr_reg <= 0;
    else if (since_wr_reg < 9) since_wr_reg <= since_wr_reg + 1;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  chk_start_gate: assert property ($rose(o_cpu_halt) |-> ($past(i_store_program_instr)
    && !$past(i_self_program_enable) && !$past(i_eeprom_busy))) else $error("op start ungated");
  chk_arm_window: assert property ($rose(o_cpu_halt) |-> since_wr_reg inside {[1:4]})
    else $error("op start outside arming window");
  chk_halt_op: assert property (o_cpu_halt == (o_flash_erase || o_flash_write))
    else $error("halt differs from operation");
  chk_op_time: assert property ($fell(o_cpu_halt) |->
    (halt_cnt_reg >= OP_MIN_CYC && halt_cnt_reg <= OP_MAX_CYC)) else $error("op length off");
  chk_we_write: assert property (o_flash_we |-> o_flash_write)
    else $error("word strobe outside page write");
  chk_we_order: assert property ($rose(o_flash_we) |-> o_flash_word == 0
    ##1 (o_flash_we && o_flash_word == 1)) else $error("page words not in sequence");
  chk_erase_page: assert property ($rose(o_flash_erase) |-> o_flash_page == $past(ptr_page))
    else $error("erase page not from pointer");
  chk_page_hold: assert property (o_cpu_halt && $past(o_cpu_halt) |-> $stable(o_flash_page))
    else $error("page moved during op");
  cov_erase: cover property ($rose(o_flash_erase));
  cov_write: cover property ($rose(o_flash_write));
  cov_we: cover property ($rose(o_flash_we));
endmodule : fsps_sequencer_properties
`default_nettype wire

// ===== test_fsps_sequencer.sv
`timescale 1ns/1ns
`default_nettype none
module test_fsps_sequencer;
  import fsps_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic fuse = 1'b1;
  logic ee_busy = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [7:0] rdata;
  logic instr, halt, erase, write, we;
  logic [12:0] ptr;
  logic [15:0] ldata, fdata;
  logic [6:0] page;
  logic [4:0] word;
  logic [15:0] exp_mem [32];
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int we_cnt = 0;
  int halt_cnt = 0;
  always #25 i_clk = ~i_clk;
  fsps_sequencer i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_self_program_enable(fuse),
    .i_eeprom_busy(ee_busy), .i_addr(addr), .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s),
    .o_rdata(rdata), .i_store_program_instr(instr), .i_pointer(ptr), .i_load_data_pair(ldata),
    .o_cpu_halt(halt), .o_flash_erase(erase), .o_flash_write(write), .o_flash_page(page),
    .o_flash_word(word), .o_flash_data(fdata), .o_flash_we(we));
  fsps_cpu_model u_cpu (.i_clk(i_clk), .i_halt(halt), .o_instr(instr), .o_pointer(ptr),
    .o_data(ldata));
  task automatic ck(input logic [15:0] seen, input logic [15:0] expd);
    n_tests++;
    if (seen !== expd) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, expd);
    end
  endtask : ck
  task automatic finish_test;
    if (err_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge i_clk);
    wr_s <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge i_clk);
    wr_s <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge i_clk);
    rd_s <= 1'b1;
    addr <= a;
    @(posedge i_clk);
    rd_s <= 1'b0;
    #1 ck({8'h00, rdata}, {8'h00, e});
  endtask : rd
  task automatic ld(input logic [4:0] w, input logic [15:0] d);
    wr(ADDR_CTRL, CMD_LOAD);
    u_cpu.store_program_instr({7'h00, w, 1'b0}, d);
    exp_mem[w] = exp_mem[w] & d;
  endtask : ld
  always @(posedge i_clk) begin
    cyc++;
    if (halt === 1'b1) halt_cnt++;
    if (we === 1'b1) begin
      ck(fdata, exp_mem[we_cnt]);
      ck({11'h000, word}, 16'(we_cnt));
      ck({9'h000, page}, 16'h002A);
      we_cnt++;
    end
    if (cyc == 95000) begin
      err_count++;
      finish_test();
    end
  end
  initial begin
    int k;
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd(ADDR_CTRL, CTRL_RESET);
    rd(ADDR_STATUS, 8'h00);
    wr(ADDR_CTRL, CMD_LOAD);
    u_cpu.store_program_instr(13'h0002, 16'h1111);
    rd(ADDR_STATUS, 8'h01);
    fuse <= 1'b0;
    wr(ADDR_CTRL, CMD_LOAD);
    repeat (3) @(posedge i_clk);
    u_cpu.store_program_instr(13'h0002, 16'h1111);
    rd(ADDR_CTRL, 8'h00);
    rd(ADDR_STATUS, 8'h00);
    ld(5'h04, 16'h2222);
    rd(ADDR_STATUS, 8'h04);
    wr(ADDR_CTRL, 8'h10);
    rd(ADDR_STATUS, 8'h00);
    ld(5'h09, 16'h3333);
    ee_busy <= 1'b1;
    @(posedge i_clk);
    rd(ADDR_STATUS, 8'h00);
    wr(ADDR_CTRL, CMD_LOAD);
    rd(ADDR_CTRL, 8'h00);
    u_cpu.store_program_instr(13'h0012, 16'h4444);
    ee_busy <= 1'b0;
    rd(ADDR_STATUS, 8'h00);
    // Fill first, then erase with a junk word field
    ld(5'h07, 16'h5555);
    wr(ADDR_CTRL, CMD_ERASE);
    u_cpu.store_program_instr(13'h0ABF, 16'h0BAD);
    repeat (20) @(posedge i_clk);
    #1 ck({13'h0000, halt, erase, write}, 16'h0006);
    ck({9'h000, page}, 16'h002A);
    rd(ADDR_STATUS, 8'h06);
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    #1 ck({15'h0000, halt}, 16'h0000);
    rd(ADDR_STATUS, 8'h00);
    foreach (exp_mem[i]) exp_mem[i] = 16'hFFFF;
    ld(5'h1F, 16'hA5A5);
    ld(5'h00, 16'h0F0F);
    ld(5'h11, 16'h1234);
    halt_cnt = 0;
    wr(ADDR_CTRL, CMD_WRITE);
    u_cpu.store_program_instr(13'h0A80, 16'hFFFF);
    @(posedge i_clk);
    #1 ck({13'h0000, halt, erase, write}, 16'h0005);
    for (k = 0; k < OP_MAX_CYC && halt !== 1'b0; k++) @(posedge i_clk);
    ck(16'(we_cnt), 16'h0020);
    ck({15'h0000, (halt_cnt >= OP_MIN_CYC && halt_cnt <= OP_MAX_CYC)}, 16'h0001);
    rd(ADDR_STATUS, 8'h00);
    rd(ADDR_CTRL, 8'h00);
    finish_test();
  end
endmodule : test_fsps_sequencer
bind fsps_sequencer fsps_sequencer_properties #(.WORD_BITS(WORD_BITS), .PAGE_BITS(PAGE_BITS))
  u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_self_program_enable(i_self_program_enable),
  .i_eeprom_busy(i_eeprom_busy), .i_addr(i_addr), .i_wr(i_wr),
  .i_store_program_instr(i_store_program_instr), .i_pointer(i_pointer),
  .o_cpu_halt(o_cpu_halt), .o_flash_erase(o_flash_erase), .o_flash_write(o_flash_write),
  .o_flash_page(o_flash_page), .o_flash_word(o_flash_word), .o_flash_we(o_flash_we));
`default_nettype wire
